// *** rtl/dma_cell_pkg.sv ***
// package: register map, field positions and types of the dma channel cell/status block
package dma_cell_pkg;
    // register byte offsets
    localparam logic [7:0] off_interrupt_control = 8'h00;
    localparam logic [7:0] off_cell_size         = 8'h04;
    localparam logic [7:0] off_cell_pointer      = 8'h08;
    localparam logic [7:0] off_source_size       = 8'h0c;
    localparam logic [7:0] off_dest_size         = 8'h10;
    localparam logic [7:0] off_channel_control   = 8'h14;
    localparam logic [7:0] off_dest_pointer      = 8'h18;
    // flag bit positions in the interrupt control register
    localparam int bit_address_error  = 0;
    localparam int bit_transfer_abort = 1;
    localparam int bit_cell_complete  = 2;
    localparam int bit_block_complete = 3;
    localparam int bit_dest_half_full = 4;
    localparam int flag_width         = 5;
    // channel control fields
    localparam int bit_enable         = 0;
    localparam int bit_pattern_mode   = 1;
    localparam int pos_abort_select   = 8;
    localparam int abort_select_width = 8;
    // reset values
    localparam logic [15:0] cell_size_reset = 16'h0000;
    localparam logic [15:0] size_reset      = 16'h0000;

    typedef struct packed
    {
        logic [7:0] data;
    } byte_word_t;

    typedef enum logic [1:0]
    {
        st_idle   = 2'b00,
        st_run    = 2'b01,
        st_stall  = 2'b10
    } chan_state_t;
endpackage

// *** rtl/dma_channel_cell_status.sv ***
// dma channel cell size, cell pointer and interrupt flag logic with apb slave
//
// Function
// - dest_half_full_flag (bit 4) sets when the destination position reaches half the destination size.
// - block_complete_flag (bit 3) sets when the larger of source and destination size is moved or on a pattern match.
// - cell_complete_flag (bit 2) sets when cell_byte_count bytes of the current cell have moved.
// - a request matching abort_request_select aborts the transfer and sets transfer_abort_flag (bit 1).
// - address_error_flag (bit 0) sets when the source or destination address is reported invalid.
// - cell size register holds a read/write 16-bit byte count in bits 15-0, reset zero, all ones meaning 65,535 bytes.
// - bits 31-16 of cell size and cell pointer read zero and ignore writes.
// - cell pointer is a read-only 16-bit byte position, reset zero, unaffected by writes.
// - in pattern-detect mode the cell pointer returns to zero on each pattern detect.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_cell_status
    import dma_cell_pkg::*;
#(
    parameter int irq_width = 8
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire logic             src_valid,
    output logic                  src_ready,
    input  wire byte_word_t       src_data,
    output logic                  dst_valid,
    input  wire logic             dst_ready,
    output byte_word_t            dst_data,
    input  wire logic [irq_width-1:0] irq_lines,
    input  wire logic             pattern_detect,
    input  wire logic             address_invalid,
    output logic                  channel_busy
);
    // =========================================================
    // registers
    // =========================================================
    logic [flag_width-1:0] flags;
    logic [15:0]           cell_byte_count;
    logic [15:0]           cell_byte_position;
    logic [15:0]           source_byte_count;
    logic [15:0]           dest_byte_count;
    logic [15:0]           dest_byte_position;
    logic [15:0]           block_position;
    logic                  chan_enable;
    logic                  pattern_mode;
    logic [7:0]            abort_request_select;
    chan_state_t           state;
    chan_state_t           next_state;
    logic                  abort_now;


    // =========================================================
    // apb decode
    // =========================================================
    wire wr_access = psel && penable && pwrite;
    wire rd_access = psel && !pwrite;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
    wire sel_int   = hit(paddr, off_interrupt_control);
    wire sel_csize = hit(paddr, off_cell_size);
    wire sel_cptr  = hit(paddr, off_cell_pointer);
    wire sel_ssize = hit(paddr, off_source_size);
    wire sel_dsize = hit(paddr, off_dest_size);
    wire sel_ctrl  = hit(paddr, off_channel_control);
    wire sel_dptr  = hit(paddr, off_dest_pointer);
    wire mapped    = sel_int | sel_csize | sel_cptr | sel_ssize | sel_dsize | sel_ctrl | sel_dptr;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire [31:0] ctrl_view = {16'h0000, abort_request_select, 6'h00, pattern_mode, chan_enable};
    wire [31:0] read_mux =
        sel_int   ? {27'h0000000, flags} :
        sel_csize ? {16'h0000, cell_byte_count} :
        sel_cptr  ? {16'h0000, cell_byte_position} :
        sel_ssize ? {16'h0000, source_byte_count} :
        sel_dsize ? {16'h0000, dest_byte_count} :
        sel_ctrl  ? ctrl_view :
        sel_dptr  ? {16'h0000, dest_byte_position} : 32'h00000000;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            prdata <= 32'h00000000;
        else if (rd_access && !penable)
            prdata <= read_mux;
    end

    // =========================================================
    // two-entry buffer in the byte path
    // =========================================================
    byte_word_t buf_mem [2];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] buf_count;
    wire        running  = (state == st_run);
    wire        buf_full = (buf_count == 2'd2);
    // stall upstream when buffer is full or the channel is not running
    assign src_ready = running && !buf_full;
    wire push = src_valid && src_ready;
    wire pop  = dst_valid && dst_ready;
    assign dst_valid = (buf_count != 2'd0);
    assign dst_data  = buf_mem[rd_ptr];

    always_ff @(posedge sys_clk)
    begin
        if (push)
            buf_mem[wr_ptr] <= src_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || abort_now)
        begin
            wr_ptr    <= 1'b0;
            rd_ptr    <= 1'b0;
            buf_count <= 2'd0;
        end
        else
        begin
            wr_ptr    <= wr_ptr ^ push;
            rd_ptr    <= rd_ptr ^ pop;
            buf_count <= buf_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // =========================================================
    // channel events
    // =========================================================
    // select is as wide as the register field; request lines beyond it never abort
    logic [irq_width-1:0] abort_mask;
    genvar gi;
    generate
        for (gi = 0; gi < irq_width; gi++)
        begin : g_abort_mask
            if (gi < abort_select_width)
            begin : g_sel
                assign abort_mask[gi] = abort_request_select[gi];
            end
            else
            begin : g_none
                assign abort_mask[gi] = 1'b0;
            end
        end
    endgenerate

    wire [15:0] larger_size   = (source_byte_count > dest_byte_count) ? source_byte_count : dest_byte_count;
    wire [15:0] next_cellpos  = cell_byte_position + 16'h0001;
    wire [15:0] next_dstpos   = dest_byte_position + 16'h0001;
    wire [15:0] next_blockpos = block_position + 16'h0001;
    // bytes left in the buffer after a stop other than an abort still drain, but no longer count; an abort drops them
    wire        moved         = pop && running;
    assign abort_now = running && |(irq_lines & abort_mask);
    wire        pattern_hit   = running && pattern_mode && pattern_detect;
    wire        cell_done     = moved && (next_cellpos == cell_byte_count);
    wire        block_done    = moved && (next_blockpos == larger_size);
    wire        half_full     = moved && (next_dstpos == {1'b0, dest_byte_count[15:1]});
    wire        addr_error    = running && address_invalid;
    wire        block_end     = block_done || pattern_hit || abort_now || addr_error;

    wire [flag_width-1:0] set_vec;
    assign set_vec[bit_dest_half_full] = half_full;
    assign set_vec[bit_block_complete] = block_done || pattern_hit;
    assign set_vec[bit_cell_complete]  = cell_done;
    assign set_vec[bit_transfer_abort] = abort_now;
    assign set_vec[bit_address_error]  = addr_error;

    // software clears by writing zero; a set in the same cycle wins
    wire [flag_width-1:0] write_keep = (wr_access && sel_int) ? pwdata[flag_width-1:0] : {flag_width{1'b1}};
    wire [flag_width-1:0] next_flags = (flags & write_keep) | set_vec;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flags <= '0;
        else
            flags <= next_flags;
    end

    // =========================================================
    // state machine
    // =========================================================
    wire start_write = wr_access && sel_ctrl && pwdata[bit_enable];
    always_comb
    begin
        next_state = state;
        case (state)
            st_idle:  next_state = start_write ? st_run : st_idle;
            st_run:   next_state = block_end ? st_stall : st_run;
            st_stall: next_state = st_idle;
            default:  next_state = st_idle;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= st_idle;
        else
            state <= next_state;
    end
    assign channel_busy = running;

    // =========================================================
    // configuration and positions
    // =========================================================
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cell_byte_count <= cell_size_reset;
        else if (wr_access && sel_csize)
            cell_byte_count <= pwdata[15:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            source_byte_count <= size_reset;
        else if (wr_access && sel_ssize)
            source_byte_count <= pwdata[15:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            dest_byte_count <= size_reset;
        else if (wr_access && sel_dsize)
            dest_byte_count <= pwdata[15:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pattern_mode         <= 1'b0;
            abort_request_select <= 8'h00;
        end
        else if (wr_access && sel_ctrl)
        begin
            pattern_mode         <= pwdata[bit_pattern_mode];
            abort_request_select <= pwdata[pos_abort_select +: abort_select_width];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            chan_enable <= 1'b0;
        else
            chan_enable <= (state == st_run) || start_write;
    end

    // cell pointer has no write path at all
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cell_byte_position <= 16'h0000;
        else if (pattern_hit || cell_done || block_end || start_write)
            cell_byte_position <= 16'h0000;
        else if (moved)
            cell_byte_position <= next_cellpos;
    end

    // destination position drives the half-full event
    always_ff @(posedge sys_clk)
    begin
        if (rst || start_write || block_end)
            dest_byte_position <= 16'h0000;
        else if (moved)
            dest_byte_position <= next_dstpos;
    end

    // block position drives the block-complete event
    always_ff @(posedge sys_clk)
    begin
        if (rst || start_write || block_end)
            block_position <= 16'h0000;
        else if (moved)
            block_position <= next_blockpos;
    end

endmodule
`default_nettype wire

// *** tb/dma_channel_cell_status_assertions.sv ***
// checker: bus and stream properties of the cell/status block
`timescale 1ns/1ps
`default_nettype none
module dma_cell_checker
    import dma_cell_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        src_ready,
    input wire logic        dst_valid,
    input wire logic        dst_ready,
    input wire byte_word_t  dst_data,
    input wire logic        address_invalid,
    input wire logic        channel_busy
);
    // ====================
    // properties
    wire logic rd_acc = psel && penable && !pwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_SIZE_HIGH: assert property (rd_acc && paddr == off_cell_size |-> prdata[31:16] == 16'h0)
        else $error("cell size upper half not zero");
    AST_PTR_HIGH: assert property (rd_acc && paddr == off_cell_pointer |-> prdata[31:16] == 16'h0)
        else $error("cell pointer upper half not zero");
    // four idle cycles cover the stall state; positions already clear on entering it
    AST_PTR_IDLE: assert property ((!channel_busy [*4]) ##0 (rd_acc && paddr == off_cell_pointer) |-> prdata == 32'h0)
        else $error("cell pointer not zero while idle");
    AST_ERR_STOP: assert property (channel_busy && address_invalid |-> ##[1:3] !channel_busy)
        else $error("address error did not stop channel");
    AST_IDLE_REFUSE: assert property (!channel_busy |-> !src_ready)
        else $error("bytes accepted while stopped");
    AST_DST_HOLD: assert property (dst_valid && !dst_ready && !channel_busy |=> dst_valid && $stable(dst_data))
        else $error("stalled byte lost or changed");
    AST_BAD_ADDR: assert property (psel && penable && paddr > off_dest_pointer |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_GOOD_ADDR: assert property (psel && penable && paddr <= off_dest_pointer && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
endmodule
bind dma_channel_cell_status dma_cell_checker u_chk (.*);
`default_nettype wire

// *** tb/dma_bus_partner.sv ***
// partner: source and destination memories on the byte stream
`timescale 1ns/1ps
`default_nettype none
module dma_bus_partner
    import dma_cell_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic [15:0] n_send,
    output logic            src_valid,
    input wire logic        src_ready,
    output byte_word_t      src_data,
    input wire logic        dst_valid,
    output logic            dst_ready,
    input wire byte_word_t  dst_data,
    output logic [15:0]     sent,
    output logic [15:0]     pops,
    output logic [15:0]     bad
);
    integer      seed = 32'ha79ac0da;
    logic [7:0]  q[$];
    logic        take;
    logic [15:0] nxt;
    initial {src_valid, dst_ready, src_data, sent, pops, bad} = '0;
    always @(posedge sys_clk)
    begin
        take = src_valid && src_ready;
        nxt = sent + {15'h0, take};
        if (take)
            q.push_back(src_data.data);
        if (dst_valid && dst_ready)
        begin
            pops <= pops + 16'h1;
            if (q.size() == 0 || q.pop_front() !== dst_data.data)
                bad <= bad + 16'h1;
        end
        // idle line shows the inverse, so a stale byte cannot pass
        if (take || !src_valid)
            src_data.data <= (nxt < n_send) ? 8'($random(seed)) : ~src_data.data;
        sent <= nxt;
        src_valid <= nxt < n_send;
        dst_ready <= ($random(seed) & 3) != 0;
    end
endmodule
`default_nettype wire

// *** tb/tb_dma_channel_cell_status.sv ***
// testbench: registers, stream and end events of the cell/status block
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_cell_status
    import dma_cell_pkg::*;
;
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pattern_detect = 1'b0, address_invalid = 1'b0;
    logic        pready, pslverr, src_valid, src_ready, dst_valid, dst_ready, channel_busy;
    logic        errv;
    logic [7:0]  paddr = 8'h00, irq_lines = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv, wv;
    logic [15:0] n_send = 16'h0, sent, pops, bad, p0;
    byte_word_t  src_data, dst_data;
    integer      seed = 32'ha79ac0da, failures = 0, checks_done = 0, m;
    dma_channel_cell_status #(.irq_width(8)) u_dut (.*);
    dma_bus_partner u_mem (.*);
    initial forever #25 sys_clk = ~sys_clk;
    // ====================
    // bus and check tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge sys_clk);
        @(posedge sys_clk);
        rdv = prdata;
        errv = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 400 && channel_busy !== 1'b0; i++) @(posedge sys_clk);
    endtask
    task automatic wait_pops(input logic [15:0] t);
        for (int i = 0; i < 400 && pops < t; i++) @(posedge sys_clk);
    endtask
    function automatic logic [31:0] fbit(input int b);
        return 32'h1 << b;
    endfunction
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ====================
    // scenarios
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(off_interrupt_control, 32'h0);
        rd(off_cell_size, 32'h0);
        chk({31'h0, errv}, 32'h0);
        rd(8'h1c, 32'h0);
        chk({31'h0, errv}, 32'h1);
        apb(1'b1, off_cell_pointer, 32'hffff_ffff);
        rd(off_cell_pointer, 32'h0);
        for (m = 0; m < 5; m++)
        begin
            wv = (m == 0) ? 32'hffff_ffff : $random(seed);
            apb(1'b1, off_cell_size, wv);
            rd(off_cell_size, {16'h0, wv[15:0]});
        end
        apb(1'b1, off_cell_size, 32'h5);
        apb(1'b1, off_source_size, 32'h8);
        apb(1'b1, off_dest_size, 32'h8);
        apb(1'b1, off_channel_control, fbit(bit_enable));
        n_send <= 16'h3;
        wait_pops(16'h3);
        rd(off_cell_pointer, 32'h3);
        rd(off_interrupt_control, 32'h0);
        n_send <= 16'h8;
        wait_idle();
        rd(off_interrupt_control, fbit(bit_dest_half_full) | fbit(bit_block_complete) | fbit(bit_cell_complete));
        chk({16'h0, pops}, 32'h8);
        apb(1'b1, off_cell_size, 32'h0);
        apb(1'b1, off_dest_size, 32'h40);
        // abort goes last: it drops buffered bytes the memory model still expects
        for (m = 0; m < 3; m++)
        begin
            apb(1'b1, off_interrupt_control, 32'h0);
            apb(1'b1, off_channel_control, 32'h0000_0403);
            p0 = pops;
            n_send <= sent + 16'd40;
            irq_lines <= 8'($random(seed)) & 8'heb;
            wait_pops(p0 + 16'h2);
            chk({31'h0, channel_busy}, 32'h1);
            pattern_detect <= (m == 0);
            address_invalid <= (m == 1);
            irq_lines <= (m == 2) ? 8'h14 : 8'h00;
            @(posedge sys_clk);
            pattern_detect <= 1'b0;
            wait_idle();
            address_invalid <= 1'b0;
            irq_lines <= 8'h00;
            rd(off_interrupt_control, fbit(m == 0 ? bit_block_complete : m == 1 ? bit_address_error : bit_transfer_abort));
            rd(off_cell_pointer, 32'h0);
        end
        chk({16'h0, bad}, 32'h0);
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
